// file: tbz_pin_model.sv
// pin-side model: slow clock source, external count pin and buzzer pins
`timescale 1ns/1ps

module tbz_pin_model (
  input wire logic pclk,
  input wire logic first_buzzer_output,
  input wire logic first_buzzer_enable,
  input wire logic second_buzzer_output,
  input wire logic second_buzzer_enable,
  output logic slow_clock_pin,
  output logic external_count_pin,
  output logic buzz1_pin,
  output logic buzz2_pin
);
  // ==========
  // pins
  // pins are pulled high while their driver is off
  assign buzz1_pin = first_buzzer_enable ? first_buzzer_output : 1'b1;
  assign buzz2_pin = second_buzzer_enable ? second_buzzer_output : 1'b1;

  initial begin
    slow_clock_pin = 1'b0;
    external_count_pin = 1'b1;
  end

  // ==========
  // stimulus
  // slow clock stands still between bursts; 8 pclk per cycle keeps it under pclk/4
  task automatic slow_ticks(input int n);
    repeat (n) begin
      @(posedge pclk);
      slow_clock_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      slow_clock_pin <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask

  // pin idles high, each call makes n falling edges
  task automatic ext_edges(input int n);
    repeat (n) begin
      @(posedge pclk);
      external_count_pin <= 1'b0;
      repeat (4) @(posedge pclk);
      external_count_pin <= 1'b1;
      repeat (3) @(posedge pclk);
    end
  endtask
endmodule // tbz_pin_model

// file: tbz_pkg.sv
// package: register map, field positions, reset values and divider figures of the timebase and buzzer timer block
package tbz_pkg;

  // ==========================================================================
  // register indices (byte address = 4 * index)
  localparam logic [9:0] TBZ_IDX_INT_FLAGS = 10'h095;
  localparam logic [9:0] TBZ_IDX_PIN_MODE = 10'h0A6;
  localparam logic [9:0] TBZ_IDX_RELOAD_LO = 10'h0CA;
  localparam logic [9:0] TBZ_IDX_RELOAD_HI = 10'h0CB;
  localparam logic [9:0] TBZ_IDX_COUNT_LO = 10'h0CC;
  localparam logic [9:0] TBZ_IDX_COUNT_HI = 10'h0CD;
  localparam logic [9:0] TBZ_IDX_AUX_THREE = 10'h0EF;
  localparam logic [9:0] TBZ_IDX_AUX_ONE = 10'h0F8;
  localparam logic [9:0] TBZ_IDX_IRQ_STATUS = 10'h100;
  localparam logic [9:0] TBZ_IDX_IRQ_MASK = 10'h101;

  // ==========================================================================
  // field positions
  localparam int TBZ_BIT_TB_FLAG = 0;
  localparam int TBZ_BIT_CLEAR = 6;
  localparam int TBZ_BIT_INPUT_SEL = 2;
  localparam int TBZ_BIT_PERIOD_LO = 3;
  localparam int TBZ_BIT_BUZ2_EN = 4;
  localparam int TBZ_BIT_BUZ1_EN = 0;
  localparam int TBZ_BIT_EV_TB = 0;
  localparam int TBZ_BIT_EV_T2OVF = 1;

  // ==========================================================================
  // reset values
  localparam logic [7:0] TBZ_RST_PIN_MODE = 8'h0E;
  localparam logic [7:0] TBZ_RST_BYTE = 8'h00;
  localparam logic [2:0] TBZ_RST_PERIOD = 3'h0;
  localparam logic [1:0] TBZ_RST_EVENTS = 2'h0;

  // ==========================================================================
  // divider figures
  localparam logic [15:0] TBZ_TB_LONGEST = 16'h8000;
  localparam int TBZ_SLOW_DIV = 16;
  localparam int TBZ_BUZ1_DIV = 64;

endpackage

// file: tbz_timer_block.sv
// design: timebase timer, second timer data path and buzzer outputs behind an APB slave
//
// Our own choice: the APB register port.
`timescale 1ns/1ps

module tbz_timer_block
  import tbz_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slow_clock_pin,
  input wire logic external_count_pin,
  input wire logic second_timer_run,
  input wire logic second_timer_counter_mode,
  input wire logic first_timer_overflow,
  input wire logic timebase_isr_enter,
  output logic timebase_flag,
  output logic second_timer_overflow,
  output logic first_buzzer_output,
  output logic first_buzzer_enable,
  output logic second_buzzer_output,
  output logic second_buzzer_enable,
  output logic irq
);

  // ==========================================================================
  // helpers
  function automatic logic tbz_fell(input logic prev, input logic cur);
    tbz_fell = prev & ~cur;
  endfunction

  function automatic logic [15:0] tbz_period(input logic [2:0] code);
    tbz_period = TBZ_TB_LONGEST >> code;
  endfunction

  // ==========================================================================
  // registers
  logic [7:0] pin_mode_ff;
  logic [7:0] reload_lo_ff;
  logic [7:0] reload_hi_ff;
  logic [15:0] count_ff;
  logic [2:0] period_ff;
  logic clear_ff;
  logic input_sel_ff;
  logic tb_flag_ff;
  logic [15:0] tb_count_ff;
  logic [1:0] ev_status_ff;
  logic [1:0] ev_mask_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic slow_s1_ff;
  logic slow_s2_ff;
  logic slow_s3_ff;
  logic ext_s1_ff;
  logic ext_s2_ff;
  logic ext_s3_ff;
  logic [3:0] slow_div_ff;
  logic slow_div_msb_d_ff;
  logic half_rate_ff;
  logic [5:0] buz1_div_ff;
  logic buz1_ff;
  logic buz2_ff;
  logic buz1_en_ff;
  logic buz2_en_ff;
  logic t2_ovf_ff;
  logic irq_ff;

  // ==========================================================================
  // apb decode
  wire [9:0] idx = paddr[11:2];
  wire access = psel & penable & ~pready_ff;
  wire done = psel & penable & pready_ff;
  wire wr_done = done & pwrite;
  wire rd_done = done & ~pwrite;
  wire hit_flags = (idx == TBZ_IDX_INT_FLAGS);
  wire hit_pin = (idx == TBZ_IDX_PIN_MODE);
  wire hit_rl_lo = (idx == TBZ_IDX_RELOAD_LO);
  wire hit_rl_hi = (idx == TBZ_IDX_RELOAD_HI);
  wire hit_cnt_lo = (idx == TBZ_IDX_COUNT_LO);
  wire hit_cnt_hi = (idx == TBZ_IDX_COUNT_HI);
  wire hit_aux_control_three = (idx == TBZ_IDX_AUX_THREE);
  wire hit_aux_control_one = (idx == TBZ_IDX_AUX_ONE);
  wire hit_stat = (idx == TBZ_IDX_IRQ_STATUS);
  wire hit_mask = (idx == TBZ_IDX_IRQ_MASK);
  wire mapped = hit_flags | hit_pin | hit_rl_lo | hit_rl_hi | hit_cnt_lo | hit_cnt_hi |
                hit_aux_control_three | hit_aux_control_one | hit_stat | hit_mask;
  wire [7:0] wbyte = pwdata[7:0];

  wire [7:0] rd_mux =
    hit_flags ? {7'h00, tb_flag_ff} :
    hit_pin ? pin_mode_ff :
    hit_rl_lo ? reload_lo_ff :
    hit_rl_hi ? reload_hi_ff :
    hit_cnt_lo ? count_ff[7:0] :
    hit_cnt_hi ? count_ff[15:8] :
    hit_aux_control_three ? {2'h0, period_ff, 3'h0} :
    hit_aux_control_one ? {1'b0, clear_ff, 3'h0, input_sel_ff, 2'h0} :
    hit_stat ? {6'h00, ev_status_ff} :
    hit_mask ? {6'h00, ev_mask_ff} : 8'h00;

  // one wait state so that read data and pready both leave flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= access;
      prdata_ff <= access ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      pslverr_ff <= access & ~mapped;
    end
  end

  // ==========================================================================
  // pin synchronisers and edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_s1_ff <= 1'b0;
      slow_s2_ff <= 1'b0;
      slow_s3_ff <= 1'b0;
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
    end else begin
      slow_s1_ff <= slow_clock_pin;
      slow_s2_ff <= slow_s1_ff;
      slow_s3_ff <= slow_s2_ff;
      ext_s1_ff <= external_count_pin;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
    end
  end

  // the slow clock is sampled, so it must be well below half of pclk
  wire slow_tick = slow_s2_ff & ~slow_s3_ff;
  wire ext_fall = tbz_fell(ext_s3_ff, ext_s2_ff);
  wire slow16_fall = tbz_fell(slow_div_msb_d_ff, slow_div_ff[3]);
  wire cnt_edge = input_sel_ff ? slow16_fall : ext_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_div_ff <= 4'h0;
      slow_div_msb_d_ff <= 1'b0;
    end else begin
      slow_div_ff <= slow_div_ff + {3'h0, slow_tick};
      slow_div_msb_d_ff <= slow_div_ff[3];
    end
  end

  // ==========================================================================
  // control registers
  wire wr_clear = wr_done & hit_aux_control_one & wbyte[TBZ_BIT_CLEAR];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_mode_ff <= TBZ_RST_PIN_MODE;
      reload_lo_ff <= TBZ_RST_BYTE;
      reload_hi_ff <= TBZ_RST_BYTE;
      period_ff <= TBZ_RST_PERIOD;
      input_sel_ff <= 1'b0;
      clear_ff <= 1'b0;
      ev_mask_ff <= TBZ_RST_EVENTS;
    end else begin
      if (wr_done & hit_pin) pin_mode_ff <= wbyte;
      if (wr_done & hit_rl_lo) reload_lo_ff <= wbyte;
      if (wr_done & hit_rl_hi) reload_hi_ff <= wbyte;
      if (wr_done & hit_aux_control_three) period_ff <= wbyte[TBZ_BIT_PERIOD_LO +: 3];
      if (wr_done & hit_aux_control_one) input_sel_ff <= wbyte[TBZ_BIT_INPUT_SEL];
      if (wr_done & hit_mask) ev_mask_ff <= wbyte[1:0];
      clear_ff <= wr_clear;
    end
  end

  // ==========================================================================
  // timebase
  wire [15:0] tb_period = tbz_period(period_ff);
  // greater-or-equal so that shortening the period never lets the count run on until it wraps
  wire tb_hit = slow_tick & (tb_count_ff >= tb_period - 16'h0001);
  wire flag_wr0 = wr_done & hit_flags & ~wbyte[TBZ_BIT_TB_FLAG];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_count_ff <= 16'h0000;
    end else if (clear_ff) begin
      tb_count_ff <= 16'h0000;
    end else if (tb_hit) begin
      tb_count_ff <= 16'h0000;
    end else if (slow_tick) begin
      tb_count_ff <= tb_count_ff + 16'h0001;
    end
  end

  // a new period end wins over a service entry or zero write in the same cycle, but not over the count clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_flag_ff <= 1'b0;
    end else if (tb_hit & ~clear_ff) begin
      tb_flag_ff <= 1'b1;
    end else if (timebase_isr_enter | flag_wr0) begin
      tb_flag_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // second timer count path; control bits live in the timer's own register
  wire t2_step = second_timer_run & (second_timer_counter_mode ? cnt_edge : half_rate_ff);
  wire t2_wrap = t2_step & (count_ff == 16'hFFFF);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_rate_ff <= 1'b0;
    end else begin
      half_rate_ff <= ~half_rate_ff;
    end
  end

  // a software byte write wins over a count step in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= 16'h0000;
      t2_ovf_ff <= 1'b0;
    end else begin
      t2_ovf_ff <= t2_wrap & ~(wr_done & (hit_cnt_lo | hit_cnt_hi));
      if (wr_done & hit_cnt_lo) begin
        count_ff[7:0] <= wbyte;
      end else if (wr_done & hit_cnt_hi) begin
        count_ff[15:8] <= wbyte;
      end else if (t2_wrap) begin
        count_ff <= {reload_hi_ff, reload_lo_ff};
      end else if (t2_step) begin
        count_ff <= count_ff + 16'h0001;
      end
    end
  end

  // ==========================================================================
  // buzzer waveforms and pin enables
  wire buz1_wrap = first_timer_overflow & (buz1_div_ff == 6'(TBZ_BUZ1_DIV - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buz1_div_ff <= 6'h00;
      buz1_ff <= 1'b0;
      buz2_ff <= 1'b0;
      buz1_en_ff <= 1'b0;
      buz2_en_ff <= 1'b0;
    end else begin
      if (first_timer_overflow) buz1_div_ff <= buz1_div_ff + 6'h01;
      if (buz1_wrap) buz1_ff <= ~buz1_ff;
      if (t2_ovf_ff) buz2_ff <= ~buz2_ff;
      buz1_en_ff <= pin_mode_ff[TBZ_BIT_BUZ1_EN];
      buz2_en_ff <= pin_mode_ff[TBZ_BIT_BUZ2_EN];
    end
  end

  // ==========================================================================
  // interrupt status, mask and line
  wire [1:0] ev_set = {t2_ovf_ff, tb_hit & ~clear_ff};
  wire stat_rd = rd_done & hit_stat;

  // an event in the read-clear cycle survives the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_status_ff <= TBZ_RST_EVENTS;
      irq_ff <= 1'b0;
    end else begin
      ev_status_ff <= (stat_rd ? 2'h0 : ev_status_ff) | ev_set;
      irq_ff <= |(((stat_rd ? 2'h0 : ev_status_ff) | ev_set) & ev_mask_ff);
    end
  end

  // ==========================================================================
  // outputs
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign timebase_flag = tb_flag_ff;
  assign second_timer_overflow = t2_ovf_ff;
  assign first_buzzer_output = buz1_ff;
  assign first_buzzer_enable = buz1_en_ff;
  assign second_buzzer_output = buz2_ff;
  assign second_buzzer_enable = buz2_en_ff;
  assign irq = irq_ff;

  // ==========================================================================
  // checks
  AST_CLEAR_SELF: assert property (@(posedge pclk) disable iff (!presetn)
    clear_ff |=> !clear_ff && tb_count_ff == 16'h0000)
    else $error("timebase clear bit did not self clear or count not reset");

  AST_TB_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
    tb_hit && !clear_ff |=> tb_flag_ff && ev_status_ff[TBZ_BIT_EV_TB])
    else $error("timebase flag not raised at period end");

  AST_TB_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
    tb_hit |=> tb_count_ff == 16'h0000)
    else $error("timebase count did not restart");

  AST_TB_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
    slow_tick && !(wr_done && hit_aux_control_three) |=> tb_count_ff < tbz_period(period_ff))
    else $error("timebase count passed selected period");

  AST_ISR_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    timebase_isr_enter && !tb_hit |=> !tb_flag_ff)
    else $error("flag not cleared on service entry");

  AST_WRITE_ONE_KEEPS: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && hit_flags && wbyte[0] && tb_flag_ff && !timebase_isr_enter |=> tb_flag_ff)
    else $error("writing one altered the flag");

  AST_T2_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
    t2_ovf_ff |-> count_ff == $past({reload_hi_ff, reload_lo_ff}))
    else $error("second timer did not reload on overflow");

  AST_BUZ2_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
    t2_ovf_ff |=> buz2_ff != $past(buz2_ff))
    else $error("second buzzer did not toggle");

  AST_BUZ1_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(buz1_ff) |-> $past(first_timer_overflow) && $past(buz1_div_ff) == 6'h3F)
    else $error("first buzzer toggled without 64 overflows");

  AST_BUZ_ENABLES: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 buz2_en_ff == $past(pin_mode_ff[4]) && buz1_en_ff == $past(pin_mode_ff[0]))
    else $error("buzzer enable does not follow pin mode");

  AST_SLOW16_DIV: assert property (@(posedge pclk) disable iff (!presetn)
    slow16_fall |-> slow_div_ff == 4'h0)
    else $error("slow clock divider edge not at a multiple of 16 ticks");

  AST_COUNT_ON_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    second_timer_counter_mode && !cnt_edge && !(wr_done && (hit_cnt_lo || hit_cnt_hi)) |=> count_ff == $past(count_ff))
    else $error("second timer moved without a selected input edge");

  AST_TB_SLOW_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    !slow_tick && !clear_ff |=> tb_count_ff == $past(tb_count_ff))
    else $error("timebase count moved without a slow tick");

  AST_WRITE_ZERO_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    flag_wr0 && !tb_hit |=> !tb_flag_ff)
    else $error("writing zero did not clear the flag");

  AST_COUNT_HI_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && hit_cnt_hi |=> count_ff[15:8] == $past(wbyte))
    else $error("count high byte write not taken");

  AST_RELOAD_LO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && hit_rl_lo |=> reload_lo_ff == $past(wbyte))
    else $error("reload low byte write not taken");

  AST_T2_OVF_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    t2_wrap && !(wr_done && (hit_cnt_lo || hit_cnt_hi)) |=> t2_ovf_ff)
    else $error("second timer wrap gave no overflow pulse");

endmodule // tbz_timer_block

// file: test_timebase_and_buzzer_timers.sv
// testbench: register access, timebase periods, second timer steps and buzzer outputs
`timescale 1ns/1ps

module test_timebase_and_buzzer_timers;
  import tbz_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic run = 1'b1, cmode = 1'b1, t0_ovf = 1'b0, isr = 1'b0, last_err;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, slow_clk, ext_pin, tb_flag, t2_ovf, b1_out, b1_en, b2_out, b2_en, irq, b1_pin, b2_pin;
  int err_count = 0, tests_run = 0, p;
  int ovf_seen = 0;

  always #2.5 pclk = ~pclk;

  always @(posedge pclk) begin
    if (t2_ovf === 1'b1) ovf_seen++;
  end

  tbz_timer_block i_tbz_timer_block (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slow_clock_pin(slow_clk), .external_count_pin(ext_pin), .second_timer_run(run),
    .second_timer_counter_mode(cmode), .first_timer_overflow(t0_ovf), .timebase_isr_enter(isr),
    .timebase_flag(tb_flag), .second_timer_overflow(t2_ovf), .first_buzzer_output(b1_out),
    .first_buzzer_enable(b1_en), .second_buzzer_output(b2_out), .second_buzzer_enable(b2_en), .irq(irq));

  tbz_pin_model i_tbz_pin_model (.pclk(pclk), .first_buzzer_output(b1_out), .first_buzzer_enable(b1_en),
    .second_buzzer_output(b2_out), .second_buzzer_enable(b2_en), .slow_clock_pin(slow_clk),
    .external_count_pin(ext_pin), .buzz1_pin(b1_pin), .buzz2_pin(b2_pin));

  // ==========
  // tasks
  task automatic end_of_test;
    $display("errors %0d tests %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [7:0] wd, output logic [31:0] rdv);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no cycle limit here: the watchdog ends a slave that never answers
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, idx, d, r);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    xfer(1'b0, idx, 8'h00, r);
    chk(r, {24'h0, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic period(input int n);
    i_tbz_pin_model.slow_ticks(n - 1);
    chk(tb_flag, 1'b0);
    i_tbz_pin_model.slow_ticks(1);
    chk(tb_flag, 1'b1);
  endtask

  // ==========
  // tests
  initial begin
    repeat (80000) @(posedge pclk);
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(TBZ_IDX_PIN_MODE, TBZ_RST_PIN_MODE);
    rd(TBZ_IDX_INT_FLAGS, 8'h00);
    rd(TBZ_IDX_AUX_THREE, 8'h00);
    rd(TBZ_IDX_RELOAD_LO, 8'h00);
    rd(TBZ_IDX_RELOAD_HI, 8'h00);
    rd(TBZ_IDX_COUNT_LO, 8'h00);
    rd(TBZ_IDX_COUNT_HI, 8'h00);
    chk(b1_pin, 1'b1);
    rd(10'h3FF, 8'h00);
    chk(last_err, 1'b1);
    // shorter periods only, the long codes would stretch the run
    for (int code = 5; code < 8; code++) begin
      p = 32768 >> code;
      wr(TBZ_IDX_AUX_THREE, 8'(code << 3));
      rd(TBZ_IDX_AUX_THREE, 8'(code << 3));
      i_tbz_pin_model.slow_ticks(p / 2);
      wr(TBZ_IDX_AUX_ONE, 8'h40);
      rd(TBZ_IDX_AUX_ONE, 8'h00);
      period(p);
      chk(irq, code != 5);
      if (code == 5) wr(TBZ_IDX_IRQ_MASK, 8'h01);
      cyc(2);
      chk(irq, 1'b1);
      rd(TBZ_IDX_IRQ_STATUS, 8'h01);
      cyc(2);
      chk(irq, 1'b0);
      rd(TBZ_IDX_INT_FLAGS, 8'h01);
      wr(TBZ_IDX_INT_FLAGS, 8'hFF);
      chk(tb_flag, 1'b1);
      if (code % 2 == 1) begin
        isr <= 1'b1;
        @(posedge pclk);
        isr <= 1'b0;
      end else wr(TBZ_IDX_INT_FLAGS, 8'hFE);
      cyc(2);
      chk(tb_flag, 1'b0);
      period(p);
      wr(TBZ_IDX_INT_FLAGS, 8'hFE);
      rd(TBZ_IDX_IRQ_STATUS, 8'h01);
    end
    // one longer code, run once without the clear step to bound the run time
    wr(TBZ_IDX_AUX_THREE, 8'h20);
    period(2048);
    wr(TBZ_IDX_INT_FLAGS, 8'hFE);
    rd(TBZ_IDX_IRQ_STATUS, 8'h01);
    wr(TBZ_IDX_RELOAD_LO, 8'h34);
    wr(TBZ_IDX_RELOAD_HI, 8'h12);
    wr(TBZ_IDX_COUNT_LO, 8'hFE);
    wr(TBZ_IDX_COUNT_HI, 8'hFF);
    rd(TBZ_IDX_RELOAD_LO, 8'h34);
    rd(TBZ_IDX_RELOAD_HI, 8'h12);
    rd(TBZ_IDX_COUNT_LO, 8'hFE);
    rd(TBZ_IDX_COUNT_HI, 8'hFF);
    i_tbz_pin_model.ext_edges(1);
    rd(TBZ_IDX_COUNT_LO, 8'hFF);
    chk(b2_out, 1'b0);
    i_tbz_pin_model.ext_edges(1);
    rd(TBZ_IDX_COUNT_LO, 8'h34);
    rd(TBZ_IDX_COUNT_HI, 8'h12);
    chk(b2_out, 1'b1);
    wr(TBZ_IDX_AUX_ONE, 8'h04);
    wr(TBZ_IDX_COUNT_LO, 8'hFF);
    wr(TBZ_IDX_COUNT_HI, 8'hFF);
    i_tbz_pin_model.ext_edges(2);
    rd(TBZ_IDX_COUNT_LO, 8'hFF);
    i_tbz_pin_model.slow_ticks(16);
    rd(TBZ_IDX_COUNT_LO, 8'h34);
    chk(b2_out, 1'b0);
    rd(TBZ_IDX_IRQ_STATUS, 8'h02);
    // timer mode: one step every two clocks while run is high
    run <= 1'b0;
    wr(TBZ_IDX_COUNT_LO, 8'h00);
    wr(TBZ_IDX_COUNT_HI, 8'h00);
    cmode <= 1'b0;
    run <= 1'b1;
    cyc(20);
    run <= 1'b0;
    rd(TBZ_IDX_COUNT_LO, 8'h0A);
    rd(TBZ_IDX_COUNT_HI, 8'h00);
    chk(b2_pin, 1'b1);
    wr(TBZ_IDX_PIN_MODE, 8'h1F);
    cyc(2);
    chk(b2_pin, 1'b0);
    chk(b1_pin, 1'b0);
    rd(TBZ_IDX_PIN_MODE, 8'h1F);
    repeat (63) begin
      @(posedge pclk);
      t0_ovf <= 1'b1;
      @(posedge pclk);
      t0_ovf <= 1'b0;
    end
    cyc(3);
    chk(b1_pin, 1'b0);
    t0_ovf <= 1'b1;
    @(posedge pclk);
    t0_ovf <= 1'b0;
    cyc(3);
    chk(b1_pin, 1'b1);
    wr(TBZ_IDX_PIN_MODE, 8'h0E);
    cyc(2);
    chk(b1_en, 1'b0);
    chk(b2_en, 1'b0);
    chk(ovf_seen, 2);
    end_of_test();
  end
endmodule // test_timebase_and_buzzer_timers
